// File: logic/pwm_generator_fault_control.sv
// Run gating and fault trigger logic for four PWM generators
// Operation
// - Enabled generator counter advances on every PWM clock
// - Disabled generator counter keeps its clock but gets no count enable, and holds
// - Per generator polarity for each of four external fault inputs
// - Per generator minimum fault period in clocks, used in its mode
// - Minimum period mode stretches fault for programmed clocks
// - Fault is OR of selected sources after polarity adjust
// - Legacy mode and reset use only external fault input 0
// - Extended source mode uses programmed trigger selection
// - Selection split: group 0 four inputs, group 1 eight triggers
// - Selection of each group reads back one bit per source
// - Status returns live triggers, or latched ones in latch mode
// - Status bit one means source active, laid out as selection
// - Latched trigger stays set until software clears it
// - Per generator bit chooses latched or direct faults
// - Fault interrupt raised from OR of generator fault triggers
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pwm_generator_fault_control
    import pwm_fault_pkg::*;
(
    input  wire logic                              clk_i,
    input  wire logic                              rst_n_i,
    input  wire logic [ADDR_W-1:0]                 address_i,
    input  wire logic                              read_i,
    input  wire logic                              write_i,
    input  wire logic [3:0]                        byteenable_i,
    input  wire logic [31:0]                       writedata_i,
    output logic [31:0]                            readdata_o,
    output logic                                   waitrequest_o,
    input  wire logic [NUM_EXT-1:0]                ext_fault_input_i,
    input  wire logic [NUM_GEN-1:0][NUM_DIGITAL_COMPARATOR_TRIGGER-1:0]  digital_comparator_trigger_i,
    output logic [NUM_GEN-1:0]                     gen_run_o,
    output logic [NUM_GEN-1:0]                     gen_fault_o,
    output logic [NUM_GEN-1:0][CNT_W-1:0]          gen_count_o,
    output logic                                   irq_o
);

    function automatic logic [1:0] gen_of(input logic [ADDR_W-1:0] a);
        gen_of = a[GEN_LSB+1:GEN_LSB];
    endfunction : gen_of

    function automatic logic [2:0] reg_of(input logic [ADDR_W-1:0] a);
        reg_of = a[REG_LSB+2:REG_LSB];
    endfunction : reg_of

    state_type s;
    state_type n;

    logic                              wr_c;
    logic                              rd_take_c;
    logic [NUM_GEN-1:0]                hit_c;
    logic [NUM_GEN-1:0][NUM_EXT-1:0]   adj_c;
    logic [NUM_GEN-1:0][NUM_EXT-1:0]   stat0_c;
    logic [NUM_GEN-1:0][NUM_DIGITAL_COMPARATOR_TRIGGER-1:0]  stat1_c;
    logic [NUM_GEN-1:0][NUM_EXT-1:0]   clr0_c;
    logic [NUM_GEN-1:0][NUM_DIGITAL_COMPARATOR_TRIGGER-1:0]  clr1_c;
    logic [NUM_GEN-1:0]                src_c;

    // One wait cycle lets read data come from a flop
    assign waitrequest_o = (read_i | write_i) & ~s.ack;
    assign readdata_o    = s.rdata;
    assign wr_c          = write_i & s.ack & (byteenable_i != 4'h0);
    assign rd_take_c     = read_i & s.ack;
    assign irq_o         = |(s.int_stat & s.int_mask);

    generate
        for (genvar g = 0; g < NUM_GEN; g++) begin : g_src
            assign hit_c[g] = wr_c & ~address_i[GLOBAL_BIT]
                            & (gen_of(address_i) == 2'(g));
            // High sense bit takes a high level as asserted
            assign adj_c[g] = ~(s.sync2 ^ s.gen[g].sense);
            assign stat0_c[g] = s.gen[g].ctrl.latch
                              ? (s.gen[g].lat0 | adj_c[g])
                              : adj_c[g];
            assign stat1_c[g] = s.gen[g].ctrl.latch
                              ? (s.gen[g].lat1
                                 | digital_comparator_trigger_i[g])
                              : digital_comparator_trigger_i[g];
            assign clr0_c[g] = (hit_c[g] && reg_of(address_i) == REG_STAT0)
                             ? writedata_i[NUM_EXT-1:0] : '0;
            assign clr1_c[g] = (hit_c[g] && reg_of(address_i) == REG_STAT1)
                             ? writedata_i[NUM_DIGITAL_COMPARATOR_TRIGGER-1:0] : '0;
            assign src_c[g] = s.gen[g].ctrl.ext_src
                            ? (|(stat0_c[g] & s.gen[g].trig0)
                               | |(stat1_c[g] & s.gen[g].trig1))
                            : stat0_c[g][0];
            assign gen_run_o[g]   = s.gen[g].ctrl.enable;
            assign gen_fault_o[g] = s.gen[g].fault;
            assign gen_count_o[g] = s.gen[g].count;
        end
    endgenerate

    always_comb begin
        logic [1:0] gi;
        logic [2:0] ri;
        gi = gen_of(address_i);
        ri = reg_of(address_i);
        n = s;
        n.ack = (read_i | write_i) & ~s.ack;
        n.sync1 = ext_fault_input_i;
        n.sync2 = s.sync1;
        if (read_i && !s.ack) begin
            n.rdata = '0;
            if (address_i == OFS_INT_STAT) begin
                n.rdata[NUM_GEN-1:0] = s.int_stat;
            end else if (address_i == OFS_INT_MASK) begin
                n.rdata[NUM_GEN-1:0] = s.int_mask;
            end else if (!address_i[GLOBAL_BIT]) begin
                unique case (ri)
                    REG_CTRL:   n.rdata[3:0] = s.gen[gi].ctrl;
                    REG_MINPER: n.rdata[PER_W-1:0] = s.gen[gi].minper;
                    REG_SENSE:  n.rdata[NUM_EXT-1:0] = s.gen[gi].sense;
                    REG_TRIG0:  n.rdata[NUM_EXT-1:0] = s.gen[gi].trig0;
                    REG_TRIG1:  n.rdata[NUM_DIGITAL_COMPARATOR_TRIGGER-1:0] = s.gen[gi].trig1;
                    REG_STAT0:  n.rdata[NUM_EXT-1:0] = stat0_c[gi];
                    REG_STAT1:  n.rdata[NUM_DIGITAL_COMPARATOR_TRIGGER-1:0] = stat1_c[gi];
                    REG_COUNT:  n.rdata[CNT_W-1:0] = s.gen[gi].count;
                endcase
            end
        end
        if (wr_c && address_i == OFS_INT_MASK) begin
            n.int_mask = writedata_i[NUM_GEN-1:0];
        end
        // Only reported bits clear, so a rise after the snapshot survives
        if (rd_take_c && address_i == OFS_INT_STAT) begin
            n.int_stat = s.int_stat & ~s.rdata[NUM_GEN-1:0];
        end
        for (int g = 0; g < NUM_GEN; g++) begin
            if (hit_c[g]) begin
                unique case (ri)
                    REG_CTRL:   n.gen[g].ctrl = writedata_i[3:0];
                    REG_MINPER: n.gen[g].minper = writedata_i[PER_W-1:0];
                    REG_SENSE:  n.gen[g].sense = writedata_i[NUM_EXT-1:0];
                    REG_TRIG0:  n.gen[g].trig0 = writedata_i[NUM_EXT-1:0];
                    REG_TRIG1:  n.gen[g].trig1 = writedata_i[NUM_DIGITAL_COMPARATOR_TRIGGER-1:0];
                    default:    n.gen[g].ctrl = s.gen[g].ctrl;
                endcase
            end
            // A source active in the clearing cycle keeps its bit
            n.gen[g].lat0 = (s.gen[g].lat0 & ~clr0_c[g]) | adj_c[g];
            n.gen[g].lat1 = (s.gen[g].lat1 & ~clr1_c[g])
                          | digital_comparator_trigger_i[g];
            if (src_c[g]) begin
                n.gen[g].timer = s.gen[g].minper;
            end else if (s.gen[g].timer != '0) begin
                n.gen[g].timer = s.gen[g].timer - 1'b1;
            end
            n.gen[g].fault = src_c[g] | (s.gen[g].ctrl.min_per
                                         & (s.gen[g].timer != '0));
            if (n.gen[g].fault && !s.gen[g].fault) begin
                n.int_stat[g] = 1'b1;
            end
            // Gating the count enable instead of the clock itself
            if (s.gen[g].ctrl.enable) begin
                n.gen[g].count = s.gen[g].count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
            for (int g = 0; g < NUM_GEN; g++) begin
                s.gen[g].sense  <= SENSE_RST;
                s.gen[g].trig0  <= TRIG0_RST;
                s.gen[g].trig1  <= TRIG1_RST;
                s.gen[g].minper <= MINPER_RST;
            end
        end else begin
            s <= n;
        end
    end

    generate
        for (genvar g = 0; g < NUM_GEN; g++) begin : g_chk
            property p_run;
                @(posedge clk_i) disable iff (!rst_n_i)
                s.gen[g].ctrl.enable |=>
                    s.gen[g].count == $past(s.gen[g].count) + 1'b1;
            endproperty
            a_run: assert property (p_run)
                else $error("enabled counter did not advance");

            property p_hold;
                @(posedge clk_i) disable iff (!rst_n_i)
                !s.gen[g].ctrl.enable |=> $stable(s.gen[g].count);
            endproperty
            a_hold: assert property (p_hold)
                else $error("disabled counter moved");

            property p_legacy;
                @(posedge clk_i) disable iff (!rst_n_i)
                (!s.gen[g].ctrl.ext_src && !s.gen[g].ctrl.min_per
                 && !s.gen[g].ctrl.latch)
                |=> gen_fault_o[g] == $past(adj_c[g][0]);
            endproperty
            a_legacy: assert property (p_legacy)
                else $error("legacy fault not input 0");

            property p_or;
                @(posedge clk_i) disable iff (!rst_n_i)
                (s.gen[g].ctrl.ext_src && !s.gen[g].ctrl.min_per
                 && !s.gen[g].ctrl.latch)
                |=> gen_fault_o[g] == $past(|(adj_c[g] & s.gen[g].trig0)
                    | |(digital_comparator_trigger_i[g]
                        & s.gen[g].trig1));
            endproperty
            a_or: assert property (p_or)
                else $error("fault not OR of selected sources");

            property p_minper;
                @(posedge clk_i) disable iff (!rst_n_i)
                (src_c[g] && s.gen[g].ctrl.min_per
                 && s.gen[g].minper >= 16'h0003
                 && !(|hit_c))
                |=> gen_fault_o[g] [*3];
            endproperty
            a_minper: assert property (p_minper)
                else $error("fault shorter than minimum period");

            property p_latch_keep;
                @(posedge clk_i) disable iff (!rst_n_i)
                1'b1 |=> (($past(s.gen[g].lat0 & ~clr0_c[g])
                           & ~s.gen[g].lat0) == '0);
            endproperty
            a_latch_keep: assert property (p_latch_keep)
                else $error("latched trigger lost without clear");

            property p_latch_set;
                @(posedge clk_i) disable iff (!rst_n_i)
                1'b1 |=> (($past(digital_comparator_trigger_i[g])
                           & ~s.gen[g].lat1) == '0);
            endproperty
            a_latch_set: assert property (p_latch_set)
                else $error("active trigger not latched");

            property p_irq;
                @(posedge clk_i) disable iff (!rst_n_i)
                ($rose(gen_fault_o[g]) && s.int_mask[g])
                |-> ##[0:1] irq_o;
            endproperty
            a_irq: assert property (p_irq)
                else $error("fault rise gave no interrupt");

            property p_sense_low;
                @(posedge clk_i) disable iff (!rst_n_i)
                (!s.gen[g].ctrl.ext_src && !s.gen[g].ctrl.latch
                 && !s.gen[g].sense[0] && !s.sync2[0])
                |=> gen_fault_o[g];
            endproperty
            a_sense_low: assert property (p_sense_low)
                else $error("low sense fault not seen");

            property p_sense_high;
                @(posedge clk_i) disable iff (!rst_n_i)
                (!s.gen[g].ctrl.ext_src && !s.gen[g].ctrl.latch
                 && !s.gen[g].ctrl.min_per
                 && s.gen[g].sense[0] && !s.sync2[0])
                |=> !gen_fault_o[g];
            endproperty
            a_sense_high: assert property (p_sense_high)
                else $error("high sense fault on low level");

            property p_stretch;
                @(posedge clk_i) disable iff (!rst_n_i)
                (s.gen[g].ctrl.min_per && s.gen[g].timer != 16'h0000)
                |=> gen_fault_o[g];
            endproperty
            a_stretch: assert property (p_stretch)
                else $error("fault dropped while period timer ran");

            property p_reload;
                @(posedge clk_i) disable iff (!rst_n_i)
                src_c[g] |=> s.gen[g].timer == $past(s.gen[g].minper);
            endproperty
            a_reload: assert property (p_reload)
                else $error("period timer not reloaded");

            property p_countdown;
                @(posedge clk_i) disable iff (!rst_n_i)
                (!src_c[g] && s.gen[g].timer != 16'h0000)
                |=> s.gen[g].timer == $past(s.gen[g].timer) - 16'h0001;
            endproperty
            a_countdown: assert property (p_countdown)
                else $error("period timer did not count down");

            property p_latch_clear;
                @(posedge clk_i) disable iff (!rst_n_i)
                ((clr0_c[g] & ~adj_c[g]) != 4'h0)
                |=> (s.gen[g].lat0 & $past(clr0_c[g] & ~adj_c[g])) == 4'h0;
            endproperty
            a_latch_clear: assert property (p_latch_clear)
                else $error("cleared trigger stayed latched");

            property p_int_set;
                @(posedge clk_i) disable iff (!rst_n_i)
                $rose(gen_fault_o[g]) |-> s.int_stat[g];
            endproperty
            a_int_set: assert property (p_int_set)
                else $error("fault rise not recorded");

            property p_int_keep;
                @(posedge clk_i) disable iff (!rst_n_i)
                (s.int_stat[g] && !(rd_take_c && address_i == OFS_INT_STAT))
                |=> s.int_stat[g];
            endproperty
            a_int_keep: assert property (p_int_keep)
                else $error("interrupt status lost without read");

            property p_sel_write;
                @(posedge clk_i) disable iff (!rst_n_i)
                (hit_c[g] && reg_of(address_i) == REG_TRIG1)
                |=> s.gen[g].trig1 == $past(writedata_i[NUM_DIGITAL_COMPARATOR_TRIGGER-1:0]);
            endproperty
            a_sel_write: assert property (p_sel_write)
                else $error("group 1 selection not written");

            property p_live_stat;
                @(posedge clk_i) disable iff (!rst_n_i)
                (read_i && !s.ack && !address_i[GLOBAL_BIT]
                 && gen_of(address_i) == 2'(g)
                 && reg_of(address_i) == REG_STAT1 && !s.gen[g].ctrl.latch)
                |=> readdata_o[NUM_DIGITAL_COMPARATOR_TRIGGER-1:0]
                    == $past(digital_comparator_trigger_i[g]);
            endproperty
            a_live_stat: assert property (p_live_stat)
                else $error("live trigger status wrong");
        end
    endgenerate

    c_fault: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(gen_fault_o[0]));
    c_stretch: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        s.gen[0].ctrl.min_per && !src_c[0] && gen_fault_o[0]);
    c_irq: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(irq_o));
    c_latch: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        s.gen[2].ctrl.latch && s.gen[2].lat0[3] && !s.sync2[3]);
    c_low_sense: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        !s.gen[3].sense[0] && gen_fault_o[3]);

endmodule : pwm_generator_fault_control
`default_nettype wire

// File: logic/pwm_fault_pkg.sv
// Constants and state types of the PWM generator fault control block
package pwm_fault_pkg;
    localparam int NUM_GEN  = 4;
    localparam int NUM_EXT  = 4;
    localparam int NUM_DIGITAL_COMPARATOR_TRIGGER = 8;
    localparam int PER_W    = 16;
    localparam int CNT_W    = 16;
    localparam int ADDR_W   = 8;

    // Byte address: bit 7 global, bits 6:5 generator, bits 4:2 register
    localparam int GLOBAL_BIT = 7;
    localparam int GEN_LSB    = 5;
    localparam int REG_LSB    = 2;
    localparam logic [2:0] REG_CTRL   = 3'h0;
    localparam logic [2:0] REG_MINPER = 3'h1;
    localparam logic [2:0] REG_SENSE  = 3'h2;
    localparam logic [2:0] REG_TRIG0  = 3'h3;
    localparam logic [2:0] REG_TRIG1  = 3'h4;
    localparam logic [2:0] REG_STAT0  = 3'h5;
    localparam logic [2:0] REG_STAT1  = 3'h6;
    localparam logic [2:0] REG_COUNT  = 3'h7;
    localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h80;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h84;

    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_LATCH  = 1;
    localparam int CTRL_MINPER = 2;
    localparam int CTRL_EXTSRC = 3;

    localparam logic [NUM_EXT-1:0]  SENSE_RST  = 4'hf;
    localparam logic [NUM_EXT-1:0]  TRIG0_RST  = 4'h1;
    localparam logic [NUM_DIGITAL_COMPARATOR_TRIGGER-1:0] TRIG1_RST  = 8'h00;
    localparam logic [PER_W-1:0]    MINPER_RST = 16'h0000;

    typedef struct packed {
        logic ext_src;
        logic min_per;
        logic latch;
        logic enable;
    } gen_ctrl_type;

    typedef struct packed {
        gen_ctrl_type         ctrl;
        logic [PER_W-1:0]     minper;
        logic [NUM_EXT-1:0]   sense;
        logic [NUM_EXT-1:0]   trig0;
        logic [NUM_DIGITAL_COMPARATOR_TRIGGER-1:0]  trig1;
        logic [NUM_EXT-1:0]   lat0;
        logic [NUM_DIGITAL_COMPARATOR_TRIGGER-1:0]  lat1;
        logic [PER_W-1:0]     timer;
        logic [CNT_W-1:0]     count;
        logic                 fault;
    } gen_state_type;

    typedef struct packed {
        gen_state_type [NUM_GEN-1:0] gen;
        logic [NUM_EXT-1:0]          sync1;
        logic [NUM_EXT-1:0]          sync2;
        logic [NUM_GEN-1:0]          int_stat;
        logic [NUM_GEN-1:0]          int_mask;
        logic                        ack;
        logic [31:0]                 rdata;
    } state_type;
endpackage : pwm_fault_pkg

// File: testbench/fault_source_model.sv
// Model of the fault pins and comparator triggers
`timescale 1ns/1ps
`default_nettype none
module fault_source_model
    import pwm_fault_pkg::*;
(
    input  wire logic                             clk_i,
    input  wire logic [NUM_EXT-1:0]               pin_cmd_i,
    input  wire logic [NUM_GEN-1:0][NUM_DIGITAL_COMPARATOR_TRIGGER-1:0] trig_cmd_i,
    output var logic [NUM_EXT-1:0]                pin_o = '0,
    output var logic [NUM_GEN-1:0][NUM_DIGITAL_COMPARATOR_TRIGGER-1:0]  trig_o = '0
);
    // Levels move only after an edge, never mid-cycle
    always_ff @(posedge clk_i) begin
        pin_o  <= pin_cmd_i;
        trig_o <= trig_cmd_i;
    end
endmodule : fault_source_model
`default_nettype wire

// File: testbench/tb_pwm_generator_fault_control.sv
// Self-checking bench of the PWM fault control block
`timescale 1ns/1ps
`default_nettype none
module tb_pwm_generator_fault_control
    import pwm_fault_pkg::*;
;
    logic                             clk_i = 1'b0;
    logic                             rst_n_i = 1'b0;
    logic [ADDR_W-1:0]                address = '0;
    logic                             read = 1'b0;
    logic                             write = 1'b0;
    logic [31:0]                      wdata = '0;
    logic [3:0]                       be = 4'hf;
    logic [31:0]                      readdata;
    logic                             waitrequest;
    logic [NUM_EXT-1:0]               pins;
    logic [NUM_EXT-1:0]               pin_cmd = '0;
    logic [NUM_GEN-1:0][NUM_DIGITAL_COMPARATOR_TRIGGER-1:0] trig;
    logic [NUM_GEN-1:0][NUM_DIGITAL_COMPARATOR_TRIGGER-1:0] trig_cmd = '0;
    logic [NUM_GEN-1:0]               run;
    logic [NUM_GEN-1:0]               fault;
    logic [NUM_GEN-1:0][CNT_W-1:0]    count;
    logic                             irq;
    logic [CNT_W-1:0]                 c0;
    int                               num_errors = 0;
    int                               samples_checked = 0;

    always #2 clk_i = ~clk_i;

    fault_source_model src_model (.clk_i(clk_i), .pin_cmd_i(pin_cmd),
        .trig_cmd_i(trig_cmd), .pin_o(pins), .trig_o(trig));

    // All-zero byte enables must leave every register untouched
    pwm_generator_fault_control DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .address_i(address), .read_i(read), .write_i(write),
        .byteenable_i(be), .writedata_i(wdata), .readdata_o(readdata),
        .waitrequest_o(waitrequest), .ext_fault_input_i(pins),
        .digital_comparator_trigger_i(trig), .gen_run_o(run),
        .gen_fault_o(fault), .gen_count_o(count), .irq_o(irq));

    task automatic finish_test;
        $display("Checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string n, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask : check

    function automatic logic [7:0] ra(input int g, input logic [2:0] r);
        return {1'b0, 2'(g), r, 2'b00};
    endfunction : ra

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        address <= a;
        wdata   <= d;
        write   <= 1'b1;
        @(posedge clk_i iff !waitrequest);
        write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input string n);
        @(posedge clk_i);
        address <= a;
        read    <= 1'b1;
        @(posedge clk_i iff !waitrequest);
        check(n, readdata, exp);
        read <= 1'b0;
    endtask : rd

    task automatic fchk(input int n, input logic [3:0] exp);
        repeat (n) @(negedge clk_i);
        check("fault", 32'(fault), 32'(exp));
    endtask : fchk

    // Fault pins cross two sync stages, triggers none, so six edges cover the path
    task automatic drv(input logic [3:0] p, input logic [7:0] t1,
                       input logic [3:0] exp);
        @(posedge clk_i);
        pin_cmd     <= p;
        trig_cmd[1] <= t1;
        fchk(6, exp);
    endtask : drv

    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        finish_test();
    end

    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int g = 0; g < NUM_GEN; g++) begin
            rd(ra(g, REG_CTRL), 32'h0, "ctrl");
            rd(ra(g, REG_SENSE), 32'hf, "sense");
            rd(ra(g, REG_TRIG0), 32'h1, "trig0");
            rd(ra(g, REG_TRIG1), 32'h0, "trig1");
            rd(ra(g, REG_MINPER), 32'h0, "minper");
            wr(ra(g, REG_TRIG0), 32'hffff_fff0 | 32'(g));
            rd(ra(g, REG_TRIG0), 32'(g), "trig0");
            wr(ra(g, REG_TRIG1), 32'hffff_ff00 | (32'h3 << g));
            rd(ra(g, REG_TRIG1), 32'h3 << g, "trig1");
        end
        wr(8'h88, 32'hffff_ffff);
        rd(8'h88, 32'h0, "unmapped");
        be <= 4'h0;
        wr(ra(0, REG_MINPER), 32'h55);
        be <= 4'hf;
        rd(ra(0, REG_MINPER), 32'h0, "minper");
        // Run gating on generator 1 only
        wr(ra(1, REG_CTRL), 32'h1);
        @(negedge clk_i);
        c0 = count[1];
        repeat (5) @(negedge clk_i);
        check("count", 32'(count[1]), 32'(c0 + 16'd5));
        check("run", 32'(run), 32'h2);
        check("idle", 32'(count[0]), 32'h0);
        wr(ra(1, REG_CTRL), 32'h0);
        @(negedge clk_i);
        c0 = count[1];
        repeat (5) @(negedge clk_i);
        check("hold", 32'(count[1]), 32'(c0));
        rd(ra(1, REG_COUNT), 32'(c0), "count");
        // Legacy mode sees input 0 only
        drv(4'he, 8'h00, 4'h0);
        drv(4'h1, 8'h00, 4'hf);
        wr(ra(3, REG_SENSE), 32'he);
        drv(4'h0, 8'h00, 4'h8);
        wr(ra(3, REG_SENSE), 32'hf);
        // Extended selection on generator 1
        wr(ra(1, REG_TRIG0), 32'h4);
        wr(ra(1, REG_TRIG1), 32'h80);
        wr(ra(1, REG_CTRL), 32'h9);
        drv(4'h4, 8'h00, 4'h2);
        rd(ra(1, REG_STAT0), 32'h4, "stat0");
        drv(4'h0, 8'h40, 4'h0);
        drv(4'h0, 8'h80, 4'h2);
        rd(ra(1, REG_STAT1), 32'h80, "stat1");
        drv(4'h0, 8'h00, 4'h0);
        rd(ra(1, REG_STAT1), 32'h0, "stat1");
        // Latch mode on generator 2, history cleared first
        wr(ra(2, REG_TRIG0), 32'h8);
        wr(ra(2, REG_STAT0), 32'hf);
        wr(ra(2, REG_CTRL), 32'ha);
        rd(ra(2, REG_STAT0), 32'h0, "stat0");
        drv(4'h8, 8'h00, 4'h4);
        drv(4'h0, 8'h00, 4'h4);
        rd(ra(2, REG_STAT0), 32'h8, "stat0");
        wr(ra(2, REG_STAT0), 32'h8);
        fchk(3, 4'h0);
        rd(ra(2, REG_STAT0), 32'h0, "stat0");
        // Every generator raised its fault so far
        rd(OFS_INT_STAT, 32'hf, "int");
        rd(OFS_INT_STAT, 32'h0, "int");
        // Minimum period of 20 clocks on generator 0
        wr(ra(0, REG_MINPER), 32'd20);
        wr(ra(0, REG_CTRL), 32'h4);
        drv(4'h1, 8'h00, 4'h9);
        drv(4'h0, 8'h00, 4'h1);
        fchk(12, 4'h1);
        fchk(10, 4'h0);
        check("irq", 32'(irq), 32'h0);
        wr(OFS_INT_MASK, 32'h1);
        rd(OFS_INT_MASK, 32'h1, "mask");
        fchk(2, 4'h0);
        check("irq", 32'(irq), 32'h1);
        rd(OFS_INT_STAT, 32'h9, "int");
        repeat (2) @(negedge clk_i);
        check("irq", 32'(irq), 32'h0);
        finish_test();
    end
endmodule : tb_pwm_generator_fault_control
`default_nettype wire
